// [inc/sstc_pkg.sv]
// Shared constants and types for the sensor standby/trigger/clock control pair
package sstc_pkg;
	// ----------------------------------------
	// Control, trigger and config word field positions
	// ----------------------------------------
	localparam int CTL_STREAM_BIT   = 2;   // Streaming select
	localparam int CTL_DRIVE_BIT    = 6;   // Parallel output drive select
	localparam int CTL_GPIEN_BIT    = 8;   // General input enable
	localparam int TRIG_GLOBAL_BIT  = 0;   // Global trigger bit
	localparam int CFG_PROFILE_BIT  = 7;   // Clocking profile select
	localparam int CTL_W            = 16;  // Control word width
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CTL_RST     = 16'h0000;
	localparam logic [15:0] TRIG_RST    = 16'h0000;
	localparam logic [15:0] CFG_RST     = 16'h0000;
	localparam logic [7:0]  PREDIV_RST  = 8'h01;
	localparam logic [7:0]  MULT_RST    = 8'h10;
	localparam logic [7:0]  SYSDIV_RST  = 8'h01;
	localparam logic [7:0]  PIXDIV_RST  = 8'h0A;
	// ----------------------------------------
	// Divider limits
	// ----------------------------------------
	localparam logic [7:0]  PREDIV_MIN  = 8'h01;
	localparam logic [7:0]  PREDIV_MAX  = 8'h40;
	localparam logic [7:0]  MULT_MIN    = 8'h10;
	localparam logic [7:0]  MULT_MAX    = 8'hC8;
	localparam logic [7:0]  SYSDIV_MAX  = 8'h16;
	localparam logic [7:0]  PIXDIV_MIN  = 8'h04;
	localparam logic [7:0]  PIXDIV_MAX  = 8'h0A;
	// ----------------------------------------
	// Timing and data width
	// ----------------------------------------
	localparam int LOCK_REF_CYCLES = 6750; // Reference clocks of PLL lock wait
	localparam int DATA_W          = 10;   // Parallel data width
	// ----------------------------------------
	// Host register offsets
	// ----------------------------------------
	localparam logic [4:0] A_PINS = 5'h00; // [0] standby release, [7:4] inputs
	localparam logic [4:0] A_CMD  = 5'h04; // [31:0] word, sent with select
	localparam logic [4:0] A_SEL  = 5'h08; // [1:0] select, write launches
	localparam logic [4:0] A_STAT = 5'h0C; // Sensor status, read only
	// Host command codes
	typedef enum logic [1:0] {SSTC_CMD_CTL, SSTC_CMD_TRIG, SSTC_CMD_CFG, SSTC_CMD_DIV} sstc_cmd_t;
endpackage

// [inc/sstc_if.sv]
// Pin-level carrier between sensor control and host controller
`timescale 1ns/1ps
interface sstc_if;
	logic        standbyHw_n;    // Hardware standby, low = standby
	logic        factoryMode;    // Must be low
	logic [3:0]  gpi;            // General inputs
	logic        wrEn;           // Register write strobe
	logic [1:0]  wrSel;          // Register select
	logic [31:0] wrData;         // Write data
	logic [3:0]  gpiStatus;      // Live general input levels
	logic [2:0]  state;          // 0 hw sb,1 soft sb,2 lock,3 stream
	logic        triggerActive;  // Global trigger
	logic        profileSel;     // Clocking profile
	logic        divLegal;       // Divider setting within limits
	logic        parOe;          // Parallel bus/pixel clock enable
	logic        serOe;          // Serial pads enable
	logic        strobeOe;       // Strobe/exposure enable
	logic        strobeOut;      // Strobe level
	logic        pllActive;      // PLL output connected
	modport dev  (input standbyHw_n, factoryMode, gpi, wrEn, wrSel, wrData,
		output gpiStatus, state, triggerActive, profileSel, divLegal, parOe, serOe,
		strobeOe, strobeOut, pllActive);
	modport host (output standbyHw_n, factoryMode, gpi, wrEn, wrSel, wrData,
		input gpiStatus, state, triggerActive, profileSel, divLegal, parOe, serOe,
		strobeOe, strobeOut, pllActive);
endinterface

// [hdl/sstc_device.sv]
// Sensor end: pad states, general inputs, standby/trigger arbitration, PLL control
// Notes on behaviour
// - Hardware standby floats parallel outputs and pixel clock
// - Strobe outputs float in hardware, low in soft
// - Serial pads float in hardware standby
// - Host holds factory mode input low
// - General inputs work only when enable bit set
// - Live general input levels readable as status
// - Each function maps to any input set
// - Standby pin high forces soft standby
// - Trigger from global bit or pin
// - Config bit seven selects clocking profile
// - Prescaler, multiplier, dividers build output clocks; here the pixel clock comes from mclk and the array divider alone
// - Divider values checked against declared limits
// - Host picks even PLL multiplier; sstc_host passes any multiplier and leaves this to software
// - Output pixel clock never exceeds array clock
// - Host keeps divider pairs inside legal table; sstc_host passes any pair and leaves this to software
// - Output-enable pin low forces driven
// - PLL connected 6750 reference clocks after leaving standby
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sstc_device
	import sstc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic mclk,
	input  wire logic arst_n,
	input  wire logic clkEn,
	// Pins from host
	sstc_if.dev       pins,
	// Pad outputs toward the world
	output logic [DATA_W-1:0] parData,
	output logic              pixClkOut,
	output logic              lineValidOut,
	output logic              frameValidOut
);
	import sstc_pkg::*;

	// ----------------------------------------
	// State and registers
	// ----------------------------------------
	typedef enum {ST_HWSB, ST_SOFTSB, ST_LOCK, ST_STREAM} sstc_state_t;
	sstc_state_t st_r;                 // System state
	logic [15:0] ctl_r;                // Control word
	logic [15:0] trig_r;               // Trigger word
	logic [15:0] cfg_r;                // Config word
	logic [3:0]  mapOe_r;              // Output-enable input map
	logic [3:0]  mapSb_r;              // Standby input map
	logic [3:0]  mapTrg_r;             // Trigger input map
	logic [7:0]  preDiv_r;             // Prescaler divisor
	logic [7:0]  mult_r;               // VCO multiplier
	logic [7:0]  sysDiv_r;             // Output system divider
	logic [7:0]  pixDiv_r;             // Array pixel divider
	logic [12:0] lockCnt_r;            // Lock wait counter
	logic [3:0]  gpiMeta_r;            // Synchroniser first stage
	logic [3:0]  gpiSync_r;            // Synchroniser second stage
	logic [1:0]  hwSync_r;             // Standby pin synchroniser
	logic [7:0]  divCnt_r;             // Pixel clock divider count
	logic [7:0]  pixCnt_r;             // Pixel counter for dummy frame

	// Any mapped input high; unenabled or unmapped inputs count as nothing
	function automatic logic mapHit(input logic [3:0] m, input logic [3:0] g, input logic en);
		mapHit = en && |(m & g);
	endfunction

	logic gpiEn;
	logic oePinHigh;
	logic oeMapped;
	logic sbPin;
	logic trigOn;
	logic driveOn;
	logic wantStream;
	assign gpiEn      = ctl_r[CTL_GPIEN_BIT];
	assign oeMapped   = gpiEn && |mapOe_r;
	assign oePinHigh  = mapHit(mapOe_r, gpiSync_r, gpiEn);
	// Pin low forces driven; pin high defers to bit 6
	assign driveOn    = ctl_r[CTL_DRIVE_BIT] || (oeMapped && !oePinHigh);
	assign sbPin      = mapHit(mapSb_r, gpiSync_r, gpiEn);
	assign wantStream = ctl_r[CTL_STREAM_BIT] && !sbPin;
	assign trigOn     = trig_r[TRIG_GLOBAL_BIT]
		|| mapHit(mapTrg_r, gpiSync_r, gpiEn);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gpiMeta_r <= 4'h0;
			gpiSync_r <= 4'h0;
			hwSync_r  <= 2'b00;
		end else if (clkEn) begin
			gpiMeta_r <= pins.gpi;
			gpiSync_r <= gpiMeta_r;
			hwSync_r  <= {hwSync_r[0], pins.standbyHw_n};
		end
	end

	// ----------------------------------------
	// Register writes (factory mode assumed low)
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_r    <= CTL_RST;
			trig_r   <= TRIG_RST;
			cfg_r    <= CFG_RST;
			mapOe_r  <= 4'h0;
			mapSb_r  <= 4'h0;
			mapTrg_r <= 4'h0;
			preDiv_r <= PREDIV_RST;
			mult_r   <= MULT_RST;
			sysDiv_r <= SYSDIV_RST;
			pixDiv_r <= PIXDIV_RST;
		end else if (clkEn) begin
			if (!hwSync_r[1]) begin
				// Hardware standby restores control and trigger word defaults
				ctl_r  <= CTL_RST;
				trig_r <= TRIG_RST;
			end else if (pins.wrEn) begin
				case (pins.wrSel)
					SSTC_CMD_CTL: begin
						ctl_r <= pins.wrData[15:0];
					end
					SSTC_CMD_TRIG: begin
						trig_r   <= pins.wrData[15:0];
						mapOe_r  <= pins.wrData[19:16];
						mapSb_r  <= pins.wrData[23:20];
						mapTrg_r <= pins.wrData[27:24];
					end
					SSTC_CMD_CFG: begin
						cfg_r <= pins.wrData[15:0];
					end
					default: begin
						// Divisors only accepted outside streaming
						if (st_r != ST_STREAM) begin
							preDiv_r <= pins.wrData[7:0];
							mult_r   <= pins.wrData[15:8];
							sysDiv_r <= pins.wrData[23:16];
							pixDiv_r <= pins.wrData[31:24];
						end
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// System state and PLL lock wait
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_r      <= ST_HWSB;
			lockCnt_r <= 13'd0;
		end else if (clkEn) begin
			if (!hwSync_r[1]) begin
				st_r <= ST_HWSB;
			end else begin
				case (st_r)
					ST_HWSB: begin
						st_r <= ST_SOFTSB;
					end
					ST_SOFTSB: begin
						if (wantStream) begin
							st_r      <= ST_LOCK;
							lockCnt_r <= 13'(LOCK_REF_CYCLES - 1);
						end
					end
					ST_LOCK: begin
						if (!wantStream) begin
							st_r <= ST_SOFTSB;
						end else if (lockCnt_r == 13'd0) begin
							st_r <= ST_STREAM;
						end else begin
							lockCnt_r <= lockCnt_r - 13'd1;
						end
					end
					ST_STREAM: begin
						if (!wantStream) begin
							st_r <= ST_SOFTSB;
						end
					end
					default: begin
						st_r <= ST_HWSB;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Output clock chain: divider limits and pixel clock
	// ----------------------------------------
	logic legal;
	assign legal = preDiv_r >= PREDIV_MIN && preDiv_r <= PREDIV_MAX
		&& mult_r >= MULT_MIN && mult_r <= MULT_MAX
		&& sysDiv_r != 8'h00 && sysDiv_r <= SYSDIV_MAX
		&& pixDiv_r >= PIXDIV_MIN && pixDiv_r <= PIXDIV_MAX;

	// Pixel clock toggles every array-divider count; a stand-in for the real VCO
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			divCnt_r  <= 8'h00;
			pixClkOut <= 1'b0;
			pixCnt_r  <= 8'h00;
		end else if (clkEn) begin
			if (st_r != ST_STREAM) begin
				divCnt_r  <= 8'h00;
				pixClkOut <= 1'b0;
			end else if (divCnt_r >= pixDiv_r - 8'h01) begin
				divCnt_r  <= 8'h00;
				pixClkOut <= !pixClkOut;
				pixCnt_r  <= pixCnt_r + 8'h01;
			end else begin
				divCnt_r <= divCnt_r + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// Pad enables and status, all registered
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pins.gpiStatus     <= 4'h0;
			pins.state         <= 3'd0;
			pins.triggerActive <= 1'b0;
			pins.profileSel    <= 1'b0;
			pins.divLegal      <= 1'b0;
			pins.parOe         <= 1'b0;
			pins.serOe         <= 1'b0;
			pins.strobeOe      <= 1'b0;
			pins.strobeOut     <= 1'b0;
			pins.pllActive     <= 1'b0;
			parData            <= '0;
			lineValidOut       <= 1'b0;
			frameValidOut      <= 1'b0;
		end else if (clkEn) begin
			pins.gpiStatus     <= gpiSync_r;
			pins.state         <= 3'(st_r);
			pins.triggerActive <= trigOn && st_r != ST_HWSB;
			pins.profileSel    <= cfg_r[CFG_PROFILE_BIT];
			pins.divLegal      <= legal;
			pins.parOe         <= st_r != ST_HWSB && driveOn;
			pins.serOe         <= st_r == ST_STREAM;
			pins.strobeOe      <= st_r != ST_HWSB;
			pins.strobeOut     <= st_r == ST_STREAM && trigOn;
			pins.pllActive     <= st_r == ST_STREAM;
			parData            <= DATA_W'(pixCnt_r);
			lineValidOut       <= st_r == ST_STREAM;
			frameValidOut      <= st_r == ST_STREAM;
		end
	end
endmodule

// [hdl/sstc_host.sv]
// Host end: drives control pins and register words from AXI4-Lite orders
`timescale 1ns/1ps
module sstc_host
	import sstc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        clkEn,
	// Pins toward sensor
	sstc_if.host             pins,
	// AXI4-Lite slave
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import sstc_pkg::*;

	logic [31:0] word_r;        // Pending command word
	logic [4:0]  awA_r;         // Latched write address
	logic        awHave_r;      // Address held
	logic [31:0] wD_r;          // Latched write data
	logic        wHave_r;       // Data held
	logic [3:0]  status1_r;     // Status sync stage 1
	logic [3:0]  status2_r;     // Status sync stage 2

	// ----------------------------------------
	// Write channel: take address and data in any order
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready    <= 1'b1;
			s_axi_wready     <= 1'b1;
			s_axi_bvalid     <= 1'b0;
			s_axi_bresp      <= 2'b00;
			awHave_r         <= 1'b0;
			wHave_r          <= 1'b0;
			awA_r            <= 5'h00;
			wD_r             <= 32'h0000_0000;
			word_r           <= 32'h0000_0000;
			pins.standbyHw_n <= 1'b0;
			pins.factoryMode <= 1'b0;
			pins.gpi         <= 4'h0;
			pins.wrEn        <= 1'b0;
			pins.wrSel       <= 2'b00;
			pins.wrData      <= 32'h0000_0000;
		end else if (clkEn) begin
			pins.wrEn <= 1'b0;
			if (s_axi_awvalid && s_axi_awready) begin
				awA_r         <= s_axi_awaddr;
				awHave_r      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wD_r         <= s_axi_wdata;
				wHave_r      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (awHave_r && wHave_r && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'b00;
				case (awA_r)
					A_PINS: begin
						pins.standbyHw_n <= wD_r[0];
						pins.gpi         <= wD_r[7:4];
					end
					A_CMD: begin
						word_r <= wD_r;
					end
					A_SEL: begin
						// Program-side limits (even multiplier, table pairs) are software's duty
						pins.wrSel  <= wD_r[1:0];
						pins.wrData <= word_r;
						pins.wrEn   <= 1'b1;
					end
					default: begin
						s_axi_bresp <= 2'b10;
					end
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				awHave_r      <= 1'b0;
				wHave_r       <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'b00;
			status1_r     <= 4'h0;
			status2_r     <= 4'h0;
		end else if (clkEn) begin
			status1_r <= pins.gpiStatus;
			status2_r <= status1_r;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= 2'b00;
				case (s_axi_araddr)
					A_PINS: s_axi_rdata <= {24'h0, pins.gpi, 3'b000, pins.standbyHw_n};
					A_CMD:  s_axi_rdata <= word_r;
					A_SEL:  s_axi_rdata <= {30'h0, pins.wrSel};
					A_STAT: s_axi_rdata <= {21'h0, pins.pllActive, pins.divLegal,
						pins.profileSel, pins.triggerActive, pins.state, status2_r};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule

// [verification/sstc_props.sv]
// Concurrent checks on the pins between sensor end and host end
`timescale 1ns/1ps
module sstc_props
	import sstc_pkg::*;
(
	// Clock, reset, enable
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire logic        clkEn,
	// Host-driven pins
	input wire logic        factoryMode,
	input wire logic [3:0]  gpi,
	input wire logic        wrEn,
	input wire logic [1:0]  wrSel,
	input wire logic [31:0] wrData,
	// Sensor-driven pins
	input wire logic [3:0]  gpiStatus,
	input wire logic [2:0]  state,
	input wire logic        triggerActive,
	input wire logic        profileSel,
	input wire logic        parOe,
	input wire logic        serOe,
	input wire logic        strobeOe,
	input wire logic        strobeOut,
	input wire logic        pllActive
);
	int   lockCnt_r; // Cycles spent in lock
	logic cfgBit_r;  // Profile bit last sent
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	// Count held through streaming so the rise of the PLL output can be judged
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) lockCnt_r <= 0;
		else if (state == 3'h2) lockCnt_r <= lockCnt_r + 1;
		else if (state != 3'h3) lockCnt_r <= 0;
	end
	// Latch of the profile bit of each configuration word
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) cfgBit_r <= 1'h0;
		else if (wrEn && wrSel == 2'h2) cfgBit_r <= wrData[CFG_PROFILE_BIT];
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	hwsb_float_a: assert property (state == 3'h0 && $past(state) == 3'h0
		|-> !parOe && !serOe && !strobeOe) else $error("pads driven in hardware standby");
	soft_strobe_a: assert property (state == 3'h1 && $past(state) == 3'h1
		|-> strobeOe && !strobeOut) else $error("strobe not driven low in soft standby");
	factory_low_a: assert property (!factoryMode)
		else $error("factory mode input not low");
	lock_dark_a: assert property (state == 3'h2 && $past(state) == 3'h2 |-> !pllActive)
		else $error("PLL output active during lock");
	lock_len_a: assert property ($rose(pllActive)
		|-> lockCnt_r >= LOCK_REF_CYCLES && lockCnt_r <= LOCK_REF_CYCLES + 2)
		else $error("lock wait length wrong");
	stream_entry_a: assert property (state == 3'h3 && $past(state) != 3'h3
		|-> $past(state) == 3'h2) else $error("streaming entered without lock");
	profile_follow_a: assert property (wrEn && wrSel == 2'h2 |-> ##2 profileSel == cfgBit_r)
		else $error("profile select does not follow word");
	trig_bit_a: assert property (wrEn && wrSel == 2'h1 && wrData[0] |-> ##2 triggerActive)
		else $error("trigger idle with global bit set");
	trig_idle_a: assert property (wrEn && wrSel == 2'h1 && !wrData[0]
		&& wrData[27:24] == 4'h0 |-> ##2 !triggerActive) else $error("trigger without cause");
	gpi_live_a: assert property (($stable(gpi) && state != 3'h0 && clkEn) [*5]
		|-> gpiStatus == gpi) else $error("input status not live");
endmodule

// [verification/sensor_standby_trigger_clock_ctrl_tb.sv]
// Self-checking bench for the sensor end and host end joined by their pins
`timescale 1ns/1ps
module sensor_standby_trigger_clock_ctrl_tb;
	import sstc_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        mclk = 1'h0;                 // 40 MHz clock
	logic        arst_n = 1'h0;               // Async reset
	logic        clkEn = 1'h1;                // Frozen once in the input test
	logic [4:0]  awaddr = '0, araddr = '0;    // AXI addresses
	logic [31:0] wdata = '0, rdata;           // AXI data
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;                // AXI responses
	logic        fv, lv, parallel_pixel_clock_out, p;           // Valid pins, pixel clock, its last level
	logic [9:0]  parData;                     // Parallel data from sensor
	logic [7:0]  pd;                          // Last data count
	logic [31:0] s;                           // Last read word
	logic [1:0]  r;                           // Last response
	int          fail_count = 0, num_checks = 0, cyc = 0, t0;
	// ----------------------------------------
	// Design, carrier and checker
	// ----------------------------------------
	sstc_if sstc_if_inst();
	sstc_device sstc_device_inst(.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn),
		.pins(sstc_if_inst.dev), .parData(parData), .pixClkOut(parallel_pixel_clock_out),
		.lineValidOut(lv), .frameValidOut(fv));
	sstc_host sstc_host_inst(.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn),
		.pins(sstc_if_inst.host), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	sstc_props sstc_props_inst(.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn),
		.factoryMode(sstc_if_inst.factoryMode), .gpi(sstc_if_inst.gpi),
		.wrEn(sstc_if_inst.wrEn), .wrSel(sstc_if_inst.wrSel), .wrData(sstc_if_inst.wrData),
		.gpiStatus(sstc_if_inst.gpiStatus), .state(sstc_if_inst.state),
		.triggerActive(sstc_if_inst.triggerActive), .profileSel(sstc_if_inst.profileSel),
		.parOe(sstc_if_inst.parOe), .serOe(sstc_if_inst.serOe),
		.strobeOe(sstc_if_inst.strobeOe), .strobeOut(sstc_if_inst.strobeOut),
		.pllActive(sstc_if_inst.pllActive));
	// Clock and hang guard; ceiling covers two lock waits with margin
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			final_report();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkBit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Write: address and data offered together, each released once taken
	task automatic axiWrite(input logic [4:0] a, input logic [31:0] d);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid) @(posedge mclk);
		r = bresp;
		bready <= 1'h0;
	endtask
	task automatic axiRead(input logic [4:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge mclk); while (!arready);
		arvalid <= 1'h0;
		while (!rvalid) @(posedge mclk);
		s = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask
	// Pin word: standby level in bit 0, inputs in bits 7:4
	task automatic pinSet(input logic stbyN, input logic [3:0] g);
		axiWrite(5'h00, {24'h0, g, 3'h0, stbyN});
	endtask
	task automatic devWrite(input sstc_cmd_t c, input logic [31:0] w);
		axiWrite(5'h04, w);
		axiWrite(5'h08, {30'h0, c});
	endtask
	// Reads status until a field matches or tries run out, then judges it
	task automatic poll(input int lsb, input logic [31:0] m, input logic [31:0] e, input int n);
		for (int i = 0; i < n; i++) begin
			axiRead(5'h0C);
			if (((s >> lsb) & m) === e) break;
		end
		chkVal((s >> lsb) & m, e);
	endtask
	// Room for the two-stage input sync and the output register
	task automatic settle();
		repeat (8) @(posedge mclk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testHwsb();
		pinSet(1'h0, 4'h0);
		poll(4, 7, 0, 10);
		settle();
		chkBit(sstc_if_inst.parOe, 1'h0);
		chkBit(sstc_if_inst.serOe, 1'h0);
		chkBit(sstc_if_inst.strobeOe, 1'h0);
		chkBit(lv | fv, 1'h0);
		$display("hardware standby test done");
	endtask
	task automatic testSoft();
		pinSet(1'h1, 4'h0);
		poll(4, 7, 1, 20);
		chkBit(sstc_if_inst.strobeOe, 1'h1);
		chkBit(sstc_if_inst.strobeOut, 1'h0);
		chkBit(sstc_if_inst.parOe, 1'h0);
		$display("soft standby test done");
	endtask
	// Unmapped places answer with a slave error
	task automatic testBad();
		axiRead(5'h14);
		chkVal({30'h0, r}, 32'h2);
		axiWrite(5'h18, 32'h0);
		chkVal({30'h0, r}, 32'h2);
		$display("unmapped address test done");
	endtask
	task automatic testProfile();
		for (int i = 1; i >= 0; i--) begin
			devWrite(SSTC_CMD_CFG, i << CFG_PROFILE_BIT);
			poll(8, 1, i, 4);
		end
		$display("profile test done");
	endtask
	task automatic testGpi();
		devWrite(SSTC_CMD_CTL, 32'h0100);
		pinSet(1'h1, 4'hA);
		// Frozen clock enable must hold the old input status
		clkEn <= 1'h0;
		settle();
		chkVal(sstc_if_inst.gpiStatus, 32'h0);
		clkEn <= 1'h1;
		poll(0, 15, 32'hA, 10);
		pinSet(1'h1, 4'h5);
		poll(0, 15, 32'h5, 10);
		$display("input status test done");
	endtask
	// Trigger from its bit, then from two mapped inputs, then inputs disabled
	task automatic testTrig();
		devWrite(SSTC_CMD_TRIG, 32'h0000_0001);
		poll(7, 1, 1, 4);
		devWrite(SSTC_CMD_TRIG, 32'h0300_0000);
		poll(7, 1, 1, 10);
		pinSet(1'h1, 4'h8);
		poll(7, 1, 0, 10);
		pinSet(1'h1, 4'h2);
		poll(7, 1, 1, 10);
		devWrite(SSTC_CMD_CTL, 32'h0000);
		poll(7, 1, 0, 10);
		$display("trigger test done");
	endtask
	task automatic testOe();
		devWrite(SSTC_CMD_CTL, 32'h0100);
		devWrite(SSTC_CMD_TRIG, 32'h0004_0000);
		pinSet(1'h1, 4'h0);
		settle();
		chkBit(sstc_if_inst.parOe, 1'h1);
		pinSet(1'h1, 4'h4);
		settle();
		chkBit(sstc_if_inst.parOe, 1'h0);
		devWrite(SSTC_CMD_CTL, 32'h0140);
		settle();
		chkBit(sstc_if_inst.parOe, 1'h1);
		$display("output enable test done");
	endtask
	// Words are pix, sys, mult, pre; last two legal, fifth at every upper limit
	task automatic testDiv();
		logic [31:0] tbl [6] = '{32'h0B01_2001, 32'h0401_2000, 32'h0401_0E01,
			32'h0417_2001, 32'h0A16_C840, 32'h0401_2001};
		for (int i = 0; i < 6; i++) begin
			devWrite(SSTC_CMD_DIV, tbl[i]);
			poll(9, 1, i >= 4, 4);
		end
		$display("divider test done");
	endtask
	task automatic testStream();
		devWrite(SSTC_CMD_CTL, 32'h0004);
		poll(4, 7, 2, 10);
		t0 = cyc;
		chkBit(sstc_if_inst.pllActive, 1'h0);
		poll(4, 7, 3, 3000);
		chkBit(cyc - t0 >= LOCK_REF_CYCLES - 4, 1'h1);
		settle();
		chkBit(sstc_if_inst.pllActive, 1'h1);
		chkBit(fv, 1'h1);
		chkBit(lv, 1'h1);
		// Array divider of four loaded last: one toggle and one count per four cycles
		p = parallel_pixel_clock_out;
		pd = parData[7:0];
		repeat (4) @(posedge mclk);
		chkBit(parallel_pixel_clock_out, !p);
		chkVal({24'h0, parData[7:0] - pd}, 32'h1);
		devWrite(SSTC_CMD_TRIG, 32'h0010_0000);
		pinSet(1'h1, 4'h0);
		devWrite(SSTC_CMD_CTL, 32'h0104);
		pinSet(1'h1, 4'h1);
		poll(4, 7, 1, 10);
		pinSet(1'h1, 4'h0);
		poll(4, 7, 2, 10);
		poll(4, 7, 3, 3000);
		$display("streaming test done");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge mclk);
		arst_n <= 1'h1;
		testHwsb();
		testSoft();
		testBad();
		testProfile();
		testGpi();
		testTrig();
		testOe();
		testDiv();
		testStream();
		testHwsb();
		final_report();
	end
endmodule
